// [lmme_pkg.sv]
// Shared constants and types for the literal, move and multiply executor
package lmme_pkg;
	localparam int lmme_word_w = 16;
	localparam logic [7:0] lmme_op_load_literal = 8'h0E;
	localparam logic [6:0] lmme_op_store_file = 7'h37;
	localparam logic [7:0] lmme_op_mult_literal = 8'h0D;
	localparam logic [7:0] lmme_indexed_limit = 8'h5F;
	localparam logic [7:0] lmme_reset_byte = 8'h00;
	localparam int lmme_phase_bit = 8;
	localparam int lmme_bank_bit = 8;

	typedef enum logic [1:0] {
		lmme_ph_decode = 2'b00,
		lmme_ph_read = 2'b01,
		lmme_ph_process = 2'b10,
		lmme_ph_write = 2'b11
	} lmme_phase_e;

	typedef enum logic [1:0] {
		lmme_ins_none = 2'b00,
		lmme_ins_load = 2'b01,
		lmme_ins_store = 2'b10,
		lmme_ins_mult = 2'b11
	} lmme_ins_e;

	// Data memory write request
	typedef struct packed {
		logic valid;
		logic indexed;
		logic access_bank;
		logic [11:0] addr;
		logic [7:0] data;
	} lmme_file_wr_s;

	typedef struct packed {
		logic [7:0] high_byte;
		logic [7:0] low_byte;
	} lmme_product_s;
endpackage

// [lmme_mult.sv]
// Unsigned 8x8 combinational multiplier
`timescale 1ns/1ps
module lmme_mult #(
	parameter int width = 8
) (
	input wire logic [width-1:0] a,
	input wire logic [width-1:0] b,
	output logic [2*width-1:0] p
);
	// Refused at elaboration rather than at run time
	if (width < 1) begin : g_width_chk
		$error("width must be positive");
	end

	always_comb begin
		// Zero-extended, so both operands are unsigned
		p = {{width{1'b0}}, a} * {{width{1'b0}}, b};
	end
endmodule

// [lmme_exec.sv]
// Decode and execute of load-literal, store-accumulator and multiply-literal
// Behaviour
// RQ1: Opcode high byte 0E loads the low byte into the accumulator, flags kept.
// RQ2: Opcode 0110 111a ffff ffff writes the accumulator to file address f.
// RQ3: Bank bit 0 picks the access bank, bank bit 1 uses the bank select value.
// RQ4: Extended set on, bank bit 0 and f at most 5F makes the store indexed.
// RQ5: Opcode high byte 0D multiplies accumulator by the literal, unsigned.
// RQ6: The 16-bit product goes to the high and low product bytes, W kept.
// RQ7: The multiply changes no flag and reports no zero result.
// RQ8: Each instruction is one word, one cycle: decode, read, process, write.
`timescale 1ns/1ps
module lmme_exec
	import lmme_pkg::*;
#(
	parameter int access_split = 8'h80
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [lmme_pkg::lmme_word_w-1:0] instr_word,
	input wire logic [7:0] bank_select_register,
	input wire logic extended_set_en,
	output lmme_pkg::lmme_file_wr_s file_wr,
	output logic [7:0] accumulator,
	output lmme_pkg::lmme_product_s product,
	output logic [1:0] phase,
	output logic instr_done,
	output logic instr_illegal
);
	import lmme_pkg::*;

	// Both halves of the access bank must keep at least one byte
	if (access_split < 1 || access_split > 255) begin : g_split_chk
		$error("access_split out of range");
	end

	// Sequencer state
	lmme_phase_e phase_q, phase_d;
	lmme_ins_e ins_q, ins_d;
	logic [lmme_word_w-1:0] word_q, word_d;
	logic illegal_q, illegal_d;
	// Datapath state
	logic [7:0] operand_q, operand_d;
	logic [15:0] result_q, result_d;
	// Results seen by the core
	logic [7:0] acc_q, acc_d;
	lmme_product_s prod_q, prod_d;
	lmme_file_wr_s wr_q, wr_d;
	logic done_q, done_d;
	// Decode and address helpers
	lmme_ins_e ins_dec;
	logic [15:0] mult_p;
	logic [7:0] f_addr;
	logic bank_a;
	logic [3:0] page_sel;

	assign f_addr = word_q[7:0];
	assign bank_a = word_q[lmme_bank_bit];

	lmme_mult #(
		.width(8)
	) u_mult (
		.a(acc_q),
		.b(operand_q),
		.p(mult_p)
	);

	// Opcode match on the word offered in decode phase
	always_comb begin
		ins_dec = lmme_ins_none;
		if (instr_word[15:8] == lmme_op_load_literal) begin
			ins_dec = lmme_ins_load; // [RQ1]
		end else if (instr_word[15:9] == lmme_op_store_file) begin
			ins_dec = lmme_ins_store; // [RQ2]
		end else if (instr_word[15:8] == lmme_op_mult_literal) begin
			ins_dec = lmme_ins_mult; // [RQ5]
		end
	end

	// Sequencer: phase counter, held word and decoded kind
	always_comb begin
		phase_d = phase_q;
		ins_d = ins_q;
		word_d = word_q;
		illegal_d = 1'b0;
		// Phases advance each clock; one instruction per four clocks [RQ8]
		unique case (phase_q)
			lmme_ph_decode: begin
				phase_d = lmme_ph_read;
				word_d = instr_word;
				ins_d = lmme_ins_none;
				// Words outside decode phase are ignored without notice
				if (instr_valid) begin
					ins_d = ins_dec;
					illegal_d = (ins_dec == lmme_ins_none);
				end
			end
			lmme_ph_read: begin
				phase_d = lmme_ph_process;
			end
			lmme_ph_process: begin
				phase_d = lmme_ph_write;
			end
			lmme_ph_write: begin
				phase_d = lmme_ph_decode;
			end
		endcase
	end

	// Reset holds decode phase and zero state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			phase_q <= lmme_ph_decode;
			ins_q <= lmme_ins_none;
			word_q <= '0;
			illegal_q <= 1'b0;
		end else begin
			phase_q <= phase_d;
			ins_q <= ins_d;
			word_q <= word_d;
			illegal_q <= illegal_d;
		end
	end

	// Operand read in phase two, so a load just before a store is seen
	always_comb begin
		operand_d = operand_q;
		result_d = result_q;
		if (phase_q == lmme_ph_read) begin
			// Literal or accumulator as operand [RQ8]
			if (ins_q == lmme_ins_store) begin
				operand_d = acc_q;
			end else begin
				operand_d = word_q[7:0];
			end
		end
		if (phase_q == lmme_ph_process) begin
			if (ins_q == lmme_ins_mult) begin
				result_d = mult_p; // [RQ5]
			end else begin
				result_d = {8'h00, operand_q};
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			operand_q <= lmme_reset_byte;
			result_q <= 16'h0000;
		end else begin
			operand_q <= operand_d;
			result_q <= result_d;
		end
	end

	// Access bank: below the split on page 0, the rest on the top page
	always_comb begin
		if (bank_a) begin
			page_sel = bank_select_register[3:0]; // [RQ3]
		end else if (f_addr < 8'(access_split)) begin
			page_sel = 4'h0;
		end else begin
			page_sel = 4'hF;
		end
	end

	// All results land on the edge that closes the write phase
	always_comb begin
		acc_d = acc_q;
		prod_d = prod_q;
		wr_d = wr_q;
		wr_d.valid = 1'b0;
		done_d = 1'b0;
		if (phase_q == lmme_ph_write) begin
			done_d = (ins_q != lmme_ins_none); // [RQ8]
			unique case (ins_q)
				lmme_ins_load: begin
					acc_d = result_q[7:0]; // [RQ1]
				end
				lmme_ins_mult: begin
					// W kept, no flag or zero signal exists [RQ6] [RQ7]
					prod_d.high_byte = result_q[15:8];
					prod_d.low_byte = result_q[7:0];
				end
				lmme_ins_store: begin
					wr_d.valid = 1'b1; // [RQ2]
					wr_d.data = result_q[7:0];
					wr_d.access_bank = ~bank_a; // [RQ3]
					// Raw f still reported; offset is the memory's job
					wr_d.indexed = extended_set_en && !bank_a &&
						(f_addr <= lmme_indexed_limit); // [RQ4]
					wr_d.addr = {page_sel, f_addr}; // [RQ3]
				end
				lmme_ins_none: begin
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			acc_q <= lmme_reset_byte;
			prod_q <= '0;
			wr_q <= '0;
			done_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			prod_q <= prod_d;
			wr_q <= wr_d;
			done_q <= done_d;
		end
	end

	// Outputs straight from registers, no logic behind them
	assign file_wr = wr_q;
	assign accumulator = acc_q;
	assign product = prod_q;
	assign phase = phase_q;
	assign instr_done = done_q;
	assign instr_illegal = illegal_q;
endmodule

// [lmme_exec_asserts.sv]
// Port assertions for the executor
`timescale 1ns/1ps
module lmme_exec_chk
	import lmme_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic instr_valid,
	input wire logic [15:0] instr_word,
	input wire logic [7:0] bank_select_register,
	input wire logic extended_set_en,
	input wire lmme_pkg::lmme_file_wr_s file_wr,
	input wire logic [7:0] accumulator,
	input wire lmme_pkg::lmme_product_s product,
	input wire logic [1:0] phase,
	input wire logic instr_done,
	input wire logic instr_illegal
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire tk = instr_valid && phase == 2'h0;
	wire ld = tk && instr_word[15:8] == lmme_op_load_literal;
	wire st = tk && instr_word[15:9] == lmme_op_store_file;
	wire ml = tk && instr_word[15:8] == lmme_op_mult_literal;
	wire [7:0] k = instr_word[7:0];
	load_w_a: assert property (ld |-> ##4 accumulator == $past(k, 4))
		else $error("load");
	store_data_a: assert property (st |-> ##4 file_wr.valid &&
		file_wr.addr[7:0] == $past(k, 4) && file_wr.data == accumulator)
		else $error("store");
	store_bank_a: assert property (st |-> ##4
		file_wr.access_bank == !$past(instr_word[8], 4)) else $error("bank");
	bank_addr_a: assert property (file_wr.valid && !file_wr.access_bank |->
		file_wr.addr[11:8] == $past(bank_select_register[3:0]))
		else $error("bank addr");
	store_indexed_a: assert property (file_wr.valid |->
		file_wr.indexed == ($past(extended_set_en) && file_wr.access_bank
		&& file_wr.addr[7:0] <= lmme_indexed_limit)) else $error("indexed");
	mult_prod_a: assert property (ml |-> ##4
		product == {8'h00, accumulator} * {8'h00, $past(k, 4)})
		else $error("product");
	mult_quiet_a: assert property (ml |-> ##4
		$stable(accumulator) && !file_wr.valid) else $error("mult side");
	done_time_a: assert property (ld || st || ml |=>
		!instr_done [*3] ##1 instr_done) else $error("done");
	illegal_pulse_a: assert property (tk && !ld && !st && !ml |=>
		instr_illegal ##1 !instr_illegal) else $error("illegal");
	legal_quiet_a: assert property (ld || st || ml |=>
		!instr_illegal) else $error("legal flagged");
	idle_quiet_a: assert property (!instr_valid && phase == 2'h0 |->
		##4 !instr_done && !file_wr.valid) else $error("idle");
endmodule
bind lmme_exec lmme_exec_chk i_lmme_exec_chk(
	.core_clk(core_clk),
	.reset(reset),
	.instr_valid(instr_valid),
	.instr_word(instr_word),
	.bank_select_register(bank_select_register),
	.extended_set_en(extended_set_en),
	.file_wr(file_wr),
	.accumulator(accumulator),
	.product(product),
	.phase(phase),
	.instr_done(instr_done),
	.instr_illegal(instr_illegal)
);

// [lmme_exec_tb_top.sv]
// Corner and random instruction test of the executor
`timescale 1ns/1ps
module lmme_exec_tb_top;
	import lmme_pkg::*;
	logic core_clk = 0, reset = 1, instr_valid = 0, extended_set_en = 0;
	logic [15:0] instr_word = 0;
	logic [7:0] bank_select_register = 0, acc_e = 0, accumulator;
	logic [31:0] rnd = 32'h42836A99;
	lmme_file_wr_s file_wr;
	lmme_product_s product;
	logic [1:0] phase;
	logic instr_done, instr_illegal;
	int fail_count = 0, num_checks = 0, cyc = 0;
	lmme_exec i_lmme_exec(
		.core_clk(core_clk),
		.reset(reset),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.bank_select_register(bank_select_register),
		.extended_set_en(extended_set_en),
		.file_wr(file_wr),
		.accumulator(accumulator),
		.product(product),
		.phase(phase),
		.instr_done(instr_done),
		.instr_illegal(instr_illegal)
	);
	initial forever #2.5 core_clk = ~core_clk;
	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 0;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			wrap_up;
		end
	end
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Instruction kind from the opcode patterns
	function automatic lmme_ins_e kind(logic [15:0] w);
		if (w[15:8] == lmme_op_load_literal)
			return lmme_ins_load;
		if (w[15:9] == lmme_op_store_file)
			return lmme_ins_store;
		if (w[15:8] == lmme_op_mult_literal)
			return lmme_ins_mult;
		return lmme_ins_none;
	endfunction
	// Access bank splits at 80h: upper half maps to the top page
	function automatic logic [11:0] ea(logic [7:0] f, logic a, logic [3:0] b);
		return a ? {b, f} : {{4{f[7]}}, f};
	endfunction
	task automatic chk(string n, logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic run(logic [15:0] w, logic [7:0] b, logic x, logic v);
		logic [7:0] f;
		lmme_ins_e op;
		f = w[7:0];
		op = v ? kind(w) : lmme_ins_none;
		@(posedge core_clk);
		instr_word <= w;
		instr_valid <= v;
		bank_select_register <= b;
		extended_set_en <= x;
		// Held until a decode phase takes it
		do @(posedge core_clk); while (phase !== 2'h0);
		instr_valid <= 0;
		#1;
		chk("il", instr_illegal, v && kind(w) == lmme_ins_none);
		// Results stand just after the third edge past the decode
		repeat (3) @(posedge core_clk);
		#1;
		chk("done", instr_done, op != lmme_ins_none);
		if (op == lmme_ins_load) begin
			acc_e = f;
			chk("acc", accumulator, acc_e);
		end else if (op == lmme_ins_store) begin
			chk("wv", file_wr.valid, 1);
			chk("wd", file_wr.data, acc_e);
			chk("wa", file_wr.addr, ea(f, w[8], b[3:0]));
			chk("ab", file_wr.access_bank, !w[8]);
			chk("ix", file_wr.indexed,
				x && !w[8] && f <= lmme_indexed_limit);
		end else if (op == lmme_ins_mult) begin
			chk("pr", product, {8'h00, acc_e} * f);
			chk("wk", accumulator, acc_e);
			chk("nw", file_wr.valid, 0);
		end else begin
			chk("ia", accumulator, acc_e);
			chk("iv", file_wr.valid, 0);
		end
	endtask
	initial begin
		@(negedge reset);
		run(16'h0EFF, 8'h00, 0, 1);
		run(16'h0DFF, 8'h00, 0, 1);
		run(16'h0D00, 8'h00, 0, 1);
		run(16'h6E5F, 8'h03, 1, 1);
		run(16'h6E60, 8'h03, 1, 1);
		run(16'h6E80, 8'h03, 1, 1);
		run(16'h6FFF, 8'hA7, 1, 1);
		// Unknown opcode, then a load offered without valid
		run(16'h6C12, 8'h00, 0, 1);
		run(16'h0E33, 8'h00, 0, 0);
		repeat (80) begin
			rnd = lfsr(rnd);
			run({rnd[1] ? 8'h0D : rnd[0] ? 8'h0E : {7'h37, rnd[2]},
				rnd[15:8]}, rnd[23:16], rnd[24], rnd[25] | rnd[26]);
		end
		wrap_up;
	end
endmodule
